/* common/corr_header_pkg.sv */
package corr_header_pkg;

  // ------------------------------------------------------------
  // Buffer and header geometry
  // ------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 9;
  localparam int SEQ_WIDTH = 16;
  localparam logic [5:0] HDR0_LAST = 6'h13; // Fixed header, 20 octets
  localparam logic [5:0] HDR1_LAST = 6'h28; // Encoded header, at most 41 octets

  // ------------------------------------------------------------
  // Fixed binary header, first revision
  // ------------------------------------------------------------
  localparam logic [2:0] V0_VERSION = 3'h0;
  localparam logic [1:0] V0_MARK_BITS = 2'h3; // Bit 4 and spare bit 3
  localparam logic V0_LOW_BIT = 1'b0;
  localparam logic [7:0] MSG_TYPE_TPDU = 8'hFF;
  localparam logic [15:0] V0_ZERO_FILL = 16'h0000;
  localparam logic [7:0] V0_ONE_FILL = 8'hFF;

  // ------------------------------------------------------------
  // Encoded header, second revision
  // ------------------------------------------------------------
  localparam logic [7:0] BER_SEQUENCE = 8'h30;
  localparam logic [7:0] BER_LEN3 = 8'h83;
  localparam logic [7:0] BER_LEN2 = 8'h82;
  localparam logic [7:0] TAG_HDR = 8'hA1;
  localparam logic [7:0] TAG_OID = 8'h80;
  localparam logic [7:0] TAG_VER = 8'h81;
  localparam logic [7:0] TAG_CORR = 8'h83;
  localparam logic [7:0] TAG_SEQ = 8'h85;
  localparam logic [7:0] TAG_DIR = 8'h86;
  localparam logic [7:0] TAG_ICE = 8'h88;
  localparam logic [7:0] TAG_PAY = 8'h82;
  localparam logic [7:0] OID_LEN = 8'h04;
  localparam logic [31:0] OID_VALUE = 32'h0102_0304; // Arbitrary domain identifier
  localparam logic [7:0] ASN_VERSION = 8'h01;
  localparam logic [7:0] CORR_LEN = 8'h08;
  localparam logic [7:0] ONE_LEN = 8'h01;
  localparam logic [7:0] DIR_FROM_TARGET = 8'h01;
  localparam logic [7:0] DIR_TO_TARGET = 8'h02;
  localparam logic [7:0] ICE_GATEWAY = 8'h01;
  localparam logic [7:0] ICE_SERVING = 8'h02;
  localparam logic [7:0] HC_BASE = 8'h15;
  localparam logic [7:0] OPT_LEN = 8'h03;
  localparam logic [23:0] OUTER_EXTRA = 24'h00_0006;

endpackage : corr_header_pkg

/* src/wrap_counter.sv */
`timescale 1ns/1ns

module wrap_counter #(
  parameter int WIDTH = 16
) (
  input logic mclk,
  input logic rst,
  input logic clear,
  input logic step,
  output logic [WIDTH-1:0] value
);

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // Plain binary add rolls over at the top instead of sticking
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      value <= '0;
    else if (clear)
      value <= '0;
    else if (step)
      value <= value + WIDTH'(1);
  end

endmodule : wrap_counter

/* src/frame_fifo.sv */
`timescale 1ns/1ns

module frame_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input logic mclk,
  input logic rst,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level_next
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] level;

  // ------------------------------------------------------------
  // Handshake terms
  // ------------------------------------------------------------
  // Level counts the array only; the output register is one extra slot
  wire push = in_valid && in_ready;
  wire load = (level != '0) && (!out_valid || out_ready);
  assign in_ready = level < (AW+1)'(DEPTH);
  assign level_next = level + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  // Array write, no reset needed on storage
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers and level; depth is a power of two so pointers wrap
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(load);
      level <= level_next;
    end
  end

  // Registered read side keeps the consumer off the array path
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule : frame_fifo

/* src/corr_header_framer.sv */
`timescale 1ns/1ns

// What this block does
// - Fixed header version bits are zero
// - Direction bit one uplink, zero downlink
// - Second octet is message type 255
// - Payload length big-endian in octets three-four
// - Sequence number increases per packet sent
// - Octets seven-eight zero, nine-twelve 255
// - Correlation number: gateway id, charging id
// - Node bit zero gateway, one serving
// - Exactly one payload follows each header
// - Second revision is BER encoded
// - Version field omitted for EPS
// - Optional and mandatory encoded fields honoured
// - UDP: no retry, no buffering, drop
// - TCP: request connection, hold packets
// - Frames leave toward UDP or TCP
// - Second revision is the default
module corr_header_framer (
  input logic mclk,
  input logic rst,
  input logic start_valid,
  output logic start_ready,
  input logic [15:0] start_len,
  input logic start_dir,
  input logic start_node_type,
  input logic [31:0] start_gw_id,
  input logic [31:0] start_charging_id,
  input logic pay_valid,
  output logic pay_ready,
  input logic [7:0] pay_data,
  input logic pay_last,
  input logic cfg_legacy_v0,
  input logic cfg_eps,
  input logic cfg_ice_en,
  input logic cfg_tcp,
  input logic link_up,
  input logic seq_restart,
  output logic out_valid,
  input logic out_ready,
  output logic [7:0] out_data,
  output logic out_last,
  output logic conn_req,
  output logic dropped,
  output logic len_error,
  output logic [15:0] seq_now
);

  typedef enum logic [1:0] {st_idle, st_hdr, st_pay, st_drop} state_e;

  state_e state;
  state_e next_state;
  logic [5:0] idx;
  logic [15:0] rem;
  logic [15:0] next_rem;
  logic [15:0] len_q;
  logic [15:0] seq_q;
  logic [31:0] gw_q;
  logic [31:0] chg_q;
  logic dir_q;
  logic node_q;
  logic ver1_q;
  logic eps_q;
  logic ice_q;
  logic fifo_in_ready;
  logic [corr_header_pkg::FIFO_WIDTH-1:0] fifo_out;
  logic [2:0] fifo_level_next;

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  // Datagram mode never waits for the far end, so a dead link drops
  wire drop_now = !cfg_tcp && !link_up;
  wire tcp_hold = cfg_tcp && !link_up;
  wire accept = start_valid && start_ready;
  wire take = pay_valid && pay_ready;
  wire send_start = accept && !drop_now;
  wire use_v1 = !(cfg_legacy_v0 && !cfg_eps);

  // ------------------------------------------------------------
  // Header images
  // ------------------------------------------------------------
  // Ascending vectors so octet i sits at [8*i +: 8] in wire order
  wire [0:327] hdr0;
  wire [0:327] hdr1;
  wire [0:40] keep1;
  wire [1:0] seq_n;
  wire [7:0] hc;
  wire [23:0] outer_len;
  wire [7:0] dir_code;
  wire [7:0] ice_code;

  assign hdr0 = {corr_header_pkg::V0_VERSION, corr_header_pkg::V0_MARK_BITS, node_q, dir_q,
                 corr_header_pkg::V0_LOW_BIT, corr_header_pkg::MSG_TYPE_TPDU, len_q, seq_q,
                 corr_header_pkg::V0_ZERO_FILL, {4{corr_header_pkg::V0_ONE_FILL}},
                 gw_q, chg_q, 168'h0};

  // Minimal integer length: a leading zero octet only when the top bit is set
  assign seq_n = 2'(2'd1 + {1'b0, seq_q[15]} + {1'b0, |seq_q[15:7]});
  assign hc = 8'(corr_header_pkg::HC_BASE + {6'h00, seq_n}
              + (eps_q ? 8'h00 : corr_header_pkg::OPT_LEN)
              + (ice_q ? corr_header_pkg::OPT_LEN : 8'h00));
  assign outer_len = 24'(corr_header_pkg::OUTER_EXTRA + {16'h0000, hc} + {8'h00, len_q});
  assign dir_code = dir_q ? corr_header_pkg::DIR_FROM_TARGET : corr_header_pkg::DIR_TO_TARGET;
  assign ice_code = node_q ? corr_header_pkg::ICE_SERVING : corr_header_pkg::ICE_GATEWAY;

  // Encoded image carries every field; keep1 strikes what is absent
  assign hdr1 = {corr_header_pkg::BER_SEQUENCE, corr_header_pkg::BER_LEN3, outer_len,
                 corr_header_pkg::TAG_HDR, hc,
                 corr_header_pkg::TAG_OID, corr_header_pkg::OID_LEN, corr_header_pkg::OID_VALUE,
                 corr_header_pkg::TAG_VER, corr_header_pkg::ONE_LEN, corr_header_pkg::ASN_VERSION,
                 corr_header_pkg::TAG_CORR, corr_header_pkg::CORR_LEN, gw_q, chg_q,
                 corr_header_pkg::TAG_SEQ, {6'h00, seq_n}, 8'h00, seq_q,
                 corr_header_pkg::TAG_DIR, corr_header_pkg::ONE_LEN, dir_code,
                 corr_header_pkg::TAG_ICE, corr_header_pkg::ONE_LEN, ice_code,
                 corr_header_pkg::TAG_PAY, corr_header_pkg::BER_LEN2, len_q};
  assign keep1 = {{13{1'b1}}, {3{!eps_q}}, {12{1'b1}}, seq_q[15], |seq_q[15:7],
                  {4{1'b1}}, {3{ice_q}}, {4{1'b1}}};

  // ------------------------------------------------------------
  // Octet selection
  // ------------------------------------------------------------
  wire [5:0] hdr_end = ver1_q ? corr_header_pkg::HDR1_LAST : corr_header_pkg::HDR0_LAST;
  wire keep_cur = !ver1_q || keep1[idx];
  wire [7:0] cur_byte = ver1_q ? hdr1[{idx, 3'b000} +: 8] : hdr0[{idx, 3'b000} +: 8];
  wire in_hdr = state == st_hdr;
  wire hdr_push = in_hdr && keep_cur;
  wire hdr_step = in_hdr && (!keep_cur || fifo_in_ready);
  wire hdr_done = hdr_step && (idx == hdr_end);
  wire pay_push = (state == st_pay) && take;
  wire rem_one = rem == 16'h0001;
  wire fifo_in_valid = hdr_push || pay_push;
  wire hdr_last = (idx == hdr_end) && (len_q == 16'h0000);
  wire [8:0] fifo_in_data = hdr_push ? {hdr_last, cur_byte} : {rem_one, pay_data};
  wire room_next = fifo_level_next < 3'(corr_header_pkg::FIFO_DEPTH);

  // ------------------------------------------------------------
  // Frame sequencer
  // ------------------------------------------------------------
  // Header first, then exactly len payload octets, then back to idle
  always_comb
  begin
    next_state = state;
    next_rem = rem;
    case (state)
      st_idle:
      begin
        if (accept)
        begin
          next_rem = start_len;
          if (drop_now)
            next_state = (start_len == 16'h0000) ? st_idle : st_drop;
          else
            next_state = st_hdr;
        end
      end
      st_hdr:
      begin
        if (hdr_done)
          next_state = (len_q == 16'h0000) ? st_idle : st_pay;
      end
      st_pay, st_drop:
      begin
        if (take)
        begin
          next_rem = rem - 16'h0001;
          if (rem_one)
            next_state = st_idle;
        end
      end
      default:
        next_state = st_idle;
    endcase
  end

  // State, octet index and remaining count
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= st_idle;
      idx <= 6'h00;
      rem <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      rem <= next_rem;
      idx <= accept ? 6'h00 : idx + 6'(hdr_step);
    end
  end

  // Packet descriptor, frozen for the whole frame
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      {len_q, seq_q, gw_q, chg_q} <= '0;
      {dir_q, node_q, ver1_q, eps_q, ice_q} <= '0;
    end
    else if (send_start)
    begin
      len_q <= start_len;
      seq_q <= seq_now;
      gw_q <= start_gw_id;
      chg_q <= start_charging_id;
      dir_q <= start_dir;
      node_q <= start_node_type;
      ver1_q <= use_v1;
      eps_q <= cfg_eps;
      ice_q <= cfg_ice_en;
    end
  end

  // ------------------------------------------------------------
  // Registered handshakes and status
  // ------------------------------------------------------------
  // Payload ready looks one cycle ahead at the buffer level, so a
  // byte granted here always finds a free slot
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      start_ready <= 1'b0;
      pay_ready <= 1'b0;
      conn_req <= 1'b0;
      dropped <= 1'b0;
      len_error <= 1'b0;
    end
    else
    begin
      start_ready <= (next_state == st_idle) && !tcp_hold;
      pay_ready <= ((next_state == st_pay) && room_next) || (next_state == st_drop);
      conn_req <= tcp_hold;
      dropped <= accept && drop_now;
      len_error <= pay_push && (pay_last != rem_one);
    end
  end

  // ------------------------------------------------------------
  // Sequence counter and output buffer
  // ------------------------------------------------------------
  wrap_counter #(
    .WIDTH(corr_header_pkg::SEQ_WIDTH)
  ) u_seq (
    .mclk(mclk),
    .rst(rst),
    .clear(seq_restart),
    .step(send_start),
    .value(seq_now)
  );

  // Stalls upstream when the transport side stops taking octets
  frame_fifo #(
    .WIDTH(corr_header_pkg::FIFO_WIDTH),
    .DEPTH(corr_header_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(fifo_out),
    .level_next(fifo_level_next)
  );

  assign out_data = fifo_out[7:0];
  assign out_last = fifo_out[8];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  wire v0_push = hdr_push && !ver1_q;
  property p_v0_version;
    v0_push && idx == 6'h00 |-> fifo_in_data[7:5] == 3'h0 && fifo_in_data[4:3] == 2'h3
      && fifo_in_data[0] == 1'b0 && fifo_in_data[1] == dir_q && fifo_in_data[2] == node_q;
  endproperty
  a_v0_version: assert property (p_v0_version) else $error("first octet wrong");
  property p_v0_type;
    v0_push && idx == 6'h01 |-> fifo_in_data[7:0] == 8'hFF;
  endproperty
  a_v0_type: assert property (p_v0_type) else $error("message type wrong");
  // Octet index picks the half, so stalls between the two octets do not matter
  property p_v0_len;
    v0_push && (idx == 6'h02 || idx == 6'h03) |->
      fifo_in_data[7:0] == ((idx == 6'h02) ? len_q[15:8] : len_q[7:0]);
  endproperty
  a_v0_len: assert property (p_v0_len) else $error("length octet wrong");
  property p_v0_fill;
    v0_push && idx >= 6'h06 && idx <= 6'h0B |->
      fifo_in_data[7:0] == ((idx < 6'h08) ? 8'h00 : 8'hFF);
  endproperty
  a_v0_fill: assert property (p_v0_fill) else $error("filler octet wrong");
  property p_v0_corr;
    v0_push && idx == 6'h0C |-> fifo_in_data[7:0] == gw_q[31:24];
  endproperty
  a_v0_corr: assert property (p_v0_corr) else $error("correlation octet wrong");
  property p_seq_step;
    send_start && !seq_restart |=> seq_now == 16'($past(seq_now) + 16'h0001);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence did not step");
  property p_one_payload;
    state == st_pay && take && rem_one |=> state == st_idle ##1 !pay_push;
  endproperty
  a_one_payload: assert property (p_one_payload) else $error("payload overran");
  property p_udp_drop;
    accept && drop_now |=> dropped && !in_hdr && seq_now == $past(seq_now);
  endproperty
  a_udp_drop: assert property (p_udp_drop) else $error("udp drop wrong");
  property p_tcp_hold;
    tcp_hold ##1 tcp_hold |-> !start_ready && conn_req;
  endproperty
  a_tcp_hold: assert property (p_tcp_hold) else $error("tcp hold wrong");
  property p_eps_omit;
    hdr_push && ver1_q && eps_q |-> idx < 6'h0D || idx > 6'h0F;
  endproperty
  a_eps_omit: assert property (p_eps_omit) else $error("version field sent for eps");
  property p_default_v1;
    send_start && !cfg_legacy_v0 |=> ver1_q;
  endproperty
  a_default_v1: assert property (p_default_v1) else $error("default revision wrong");
  property p_no_loss;
    pay_push |-> fifo_in_ready;
  endproperty
  a_no_loss: assert property (p_no_loss) else $error("payload octet lost");

  c_v0_frame: cover property (hdr_done && !ver1_q ##[1:40] pay_push && rem_one);
  c_v1_frame: cover property (hdr_done && ver1_q && ice_q);
  c_udp_drop: cover property (accept && drop_now);
  c_seq_wrap: cover property (send_start && seq_now == 16'hFFFF);

endmodule : corr_header_framer

/* verif/facility_sink.sv */
`timescale 1ns/1ns

// ------------------------------------------------------------
// Receiving end of the framed stream
// ------------------------------------------------------------
module facility_sink (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic out_last,
  output logic out_ready,
  output int frames
);
  logic [7:0] lfsr;

  // Slow mode stalls about half the cycles, so back-pressure reaches the inputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lfsr <= 8'h5a;
      out_ready <= 1'b0;
      frames <= 0;
    end
    else
    begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      out_ready <= !slow || lfsr[0];
      if (out_valid && out_ready && out_last)
        frames <= frames + 1;
    end
  end
endmodule : facility_sink

/* verif/tb_corr_header_framer.sv */
`timescale 1ns/1ns

module tb_corr_header_framer;
  logic mclk, rst, start_valid, start_ready, start_dir, start_node_type;
  logic [15:0] start_len, seq_now, seq;
  logic [31:0] start_gw_id, start_charging_id;
  logic pay_valid, pay_ready, pay_last, cfg_legacy_v0, cfg_eps, cfg_ice_en, cfg_tcp;
  logic [7:0] pay_data, out_data;
  logic link_up, seq_restart, out_valid, out_ready, out_last, conn_req, dropped, len_error;
  logic slow;
  logic [8:0] exp_q[$];
  int errors, n_compared, seed, drops, lerrs, nframes, rx_frames, r;

  corr_header_framer i_dut (.mclk(mclk), .rst(rst), .start_valid(start_valid),
    .start_ready(start_ready), .start_len(start_len), .start_dir(start_dir),
    .start_node_type(start_node_type), .start_gw_id(start_gw_id),
    .start_charging_id(start_charging_id), .pay_valid(pay_valid), .pay_ready(pay_ready),
    .pay_data(pay_data), .pay_last(pay_last), .cfg_legacy_v0(cfg_legacy_v0),
    .cfg_eps(cfg_eps), .cfg_ice_en(cfg_ice_en), .cfg_tcp(cfg_tcp), .link_up(link_up),
    .seq_restart(seq_restart), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .out_last(out_last), .conn_req(conn_req), .dropped(dropped),
    .len_error(len_error), .seq_now(seq_now));

  facility_sink i_sink (.mclk(mclk), .rst(rst), .slow(slow), .out_valid(out_valid),
    .out_last(out_last), .out_ready(out_ready), .frames(rx_frames));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Queue cnt octets of v, most significant first
  function automatic void put_n(input logic [63:0] v, input int cnt);
    for (int i = cnt - 1; i >= 0; i--)
      exp_q.push_back({1'b0, v[8*i +: 8]});
  endfunction : put_n

  // Offers one descriptor and its payload; the model queues the expected frame
  task automatic send(input logic [15:0] len, input bit v0, input bit eps, input bit ice,
    input bit bad);
    logic [31:0] gw;
    logic [31:0] ch;
    logic [23:0] l;
    logic [7:0] n;
    logic [7:0] hc;
    logic [7:0] b;
    logic d;
    logic nd;
    bit drop;
    int w;
    gw = $random(seed);
    ch = $random(seed);
    d = $random(seed);
    nd = $random(seed);
    start_valid <= 1'b1;
    start_len <= len;
    start_dir <= d;
    start_node_type <= nd;
    start_gw_id <= gw;
    start_charging_id <= ch;
    cfg_legacy_v0 <= v0;
    cfg_eps <= eps;
    cfg_ice_en <= ice;
    w = 0;
    do
    begin
      @(posedge mclk);
      w++;
    end
    while (start_ready !== 1'b1 && w < 500);
    chk("start_ready", start_ready, 1'b1);
    // Link state as the design saw it at the take, not at the call
    drop = !cfg_tcp && !link_up;
    chk("seq_now", seq_now, seq);
    start_valid <= 1'b0;
    if (!drop && v0 && !eps)
    begin
      put_n({3'h0, 2'h3, nd, d, 1'b0, 8'hff, len, seq}, 6);
      put_n(48'h0000_ffff_ffff, 6);
      put_n({gw, ch}, 8);
    end
    else if (!drop)
    begin
      // Sequence number takes the fewest octets that keep it positive
      n = 8'h01 + (seq >= 16'h0080) + seq[15];
      hc = 8'h15 + n + (eps ? 8'h00 : 8'h03) + (ice ? 8'h03 : 8'h00);
      l = 24'h00_0006 + 24'(hc) + 24'(len);
      put_n({8'h30, 8'h83, l, 8'ha1, hc}, 7);
      put_n({16'h8004, corr_header_pkg::OID_VALUE}, 6);
      if (!eps)
        put_n(24'h81_0101, 3);
      put_n(16'h8308, 2);
      put_n({gw, ch}, 8);
      put_n({8'h85, n}, 2);
      if (seq[15])
        put_n(8'h00, 1);
      if (seq >= 16'h0080)
        put_n(seq[15:8], 1);
      put_n({seq[7:0], 16'h8601, d ? 8'h01 : 8'h02}, 4);
      if (ice)
        put_n({16'h8801, nd ? 8'h02 : 8'h01}, 3);
      put_n({16'h8282, len}, 4);
    end
    for (int i = 0; i < len; i++)
    begin
      b = $random(seed);
      pay_valid <= 1'b1;
      pay_data <= b;
      pay_last <= (i == len - 1) ^ (bad && i == 0);
      w = 0;
      do
      begin
        @(posedge mclk);
        w++;
      end
      while (pay_ready !== 1'b1 && w < 500);
      if (!drop)
        put_n(b, 1);
    end
    pay_valid <= 1'b0;
    if (!drop)
    begin
      exp_q[$][8] = 1'b1;
      seq++;
      nframes++;
    end
    // One edge between offers, so valid is never lowered and raised in one step
    @(posedge mclk);
  endtask : send

  // ------------------------------------------------------------
  // Clock, watchdog and output monitor
  // ------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // About 150 frames of at most 46 octets, each octet taking about two cycles when stalled; give ample margin
  initial
  begin
    #(8 * 40000);
    errors++;
    stop_test();
  end

  // Every accepted octet is compared with the model, last flag included
  always @(posedge mclk)
  begin
    if (dropped === 1'b1)
      drops++;
    if (len_error === 1'b1)
      lerrs++;
    if (rst === 1'b0 && out_valid === 1'b1 && out_ready === 1'b1)
    begin
      if (exp_q.size() > 0)
        chk("octet", {out_last, out_data}, exp_q.pop_front());
      else
        chk("surplus octet", 1, 0);
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    seed = 94;
    {start_valid, start_len, start_dir, start_node_type, start_gw_id} = '0;
    {start_charging_id, pay_valid, pay_data, pay_last, cfg_legacy_v0, cfg_eps} = '0;
    {cfg_ice_en, cfg_tcp, seq_restart, slow, seq} = '0;
    link_up = 1'b1;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (int i = 0; i < 4; i++)
      send(i[15:0], 1, 0, 0, 0);
    for (int i = 0; i < 4; i++)
      send(16'h0005, 0, i[1], i[0], 0);
    send(16'h0001, 1, 1, 0, 0);
    // Stalling receiver, random mix; carries the count into two sequence octets
    slow <= 1'b1;
    repeat (130)
    begin
      r = $random(seed);
      send(16'(r & 3), r[4], 1'b0, r[5], 0);
    end
    slow <= 1'b0;
    // Datagram mode with the link down discards without stepping the count
    link_up <= 1'b0;
    send(16'h0002, 1, 0, 0, 0);
    repeat (4) @(posedge mclk);
    chk("drops", drops, 1);
    // Stream mode holds the descriptor and asks for a connection
    cfg_tcp <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("conn_req", conn_req, 1'b1);
    fork
      send(16'h0002, 1, 0, 0, 0);
      begin
        repeat (8) @(posedge mclk);
        chk("start_ready", start_ready, 1'b0);
        link_up <= 1'b1;
      end
    join
    cfg_tcp <= 1'b0;
    send(16'h0003, 1, 0, 0, 1);
    repeat (4) @(posedge mclk);
    chk("len_error", lerrs, 1);
    seq_restart <= 1'b1;
    @(posedge mclk);
    seq_restart <= 1'b0;
    seq = '0;
    @(posedge mclk);
    send(16'h0000, 1, 0, 1, 0);
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++)
      @(posedge mclk);
    repeat (4) @(posedge mclk);
    chk("frames", rx_frames, nframes);
    chk("leftover octets", exp_q.size(), 0);
    stop_test();
  end
endmodule : tb_corr_header_framer
